/* File: ccpm_map.svh */
// Register indices, field positions, reset values and counts of the block
`ifndef CCPM_MAP_SVH
`define CCPM_MAP_SVH
`define CCPM_CHANNELS 7
`define CCPM_IDX_CH10_CTRL 12'hF00
`define CCPM_IDX_CH9_CTRL 12'hF03
`define CCPM_IDX_CH8_CTRL 12'hF06
`define CCPM_IDX_CH7_CTRL 12'hF09
`define CCPM_IDX_CH6_CTRL 12'hF0C
`define CCPM_IDX_CH5_CTRL 12'hF0F
`define CCPM_IDX_CH4_CTRL 12'hF12
`define CCPM_IDX_LAST 12'hF14
`define CCPM_IDX_STATUS 12'hF20
`define CCPM_IDX_MASK 12'hF21
`define CCPM_SUB_CTRL 2'h0
`define CCPM_SUB_LOW 2'h1
`define CCPM_SUB_HIGH 2'h2
`define CCPM_CTRL_RESET 6'h00
`define CCPM_PRE_FOUR 4'h3
`define CCPM_PRE_SIXTEEN 4'hF
`endif

/* File: ccpm_pkg.sv */
// Types of the capture/compare/PWM block
package ccpm_pkg;
  typedef enum logic [3:0] {
    CCPM_OFF = 4'h0,
    CCPM_CMP_TOGGLE = 4'h2,
    CCPM_CAP_FALL = 4'h4,
    CCPM_CAP_RISE = 4'h5,
    CCPM_CAP_FOUR = 4'h6,
    CCPM_CAP_SIXTEEN = 4'h7,
    CCPM_CMP_SET = 4'h8,
    CCPM_CMP_CLEAR = 4'h9,
    CCPM_CMP_IRQ = 4'hA,
    CCPM_CMP_SPECIAL = 4'hB
  } ccpm_mode_t;

  typedef struct packed {
    logic [1:0] duty_low_bits;
    logic [3:0] channel_mode_select;
  } ccpm_ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } ccpm_apb_req_t;

  typedef struct packed {
    ccpm_ctrl_t [6:0] ctrl;
    logic [6:0][15:0] value;
    logic [6:0][3:0] prescale;
    logic [6:0] match_prev;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] pin_prev;
    logic [6:0] flag;
    logic [6:0] mask;
    logic [6:0] pin;
    logic [6:0] oe;
    logic irq;
    logic timer_reset;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ccpm_state_t;
endpackage

/* File: ccpm_top.sv */
// Seven-channel capture/compare/PWM unit with APB registers
// Function
// - Seven identical channels each run capture, compare or PWM by mode.
// - Each channel holds a 16-bit value used as capture, compare or duty.
// - Mode 0000 disables the channel and clears its pin, output enable and prescaler.
// - Mode 0010 toggles the pin and sets the match flag on each match.
// - Mode 0100 captures on falling edges, mode 0101 on rising edges.
// - Mode 0110 captures every 4th rising edge, 0111 every 16th.
// - Mode 1000 starts the pin low and forces it high with flag on match.
// - Mode 1001 starts the pin high and forces it low with flag on match.
// - Mode 1010 only sets the flag on match; the pin stays general I/O.
// - Mode 1011 resets the timer on match and sets the flag.
// - The mode 1011 trigger resets only the timer, starting no conversion.
// - In PWM, control bits 5:4 are duty bits 1:0 and the low byte bits 9:2.
// - The value is two separately accessible 8-bit halves.
// - Channels may share one timer when in the same class of mode.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "ccpm_map.svh"
module ccpm_top
  import ccpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire ccpm_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] timer_value,
  input wire logic [9:0] pwm_count,
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe,
  output logic timer_reset,
  output logic irq
);

  ccpm_state_t s;
  ccpm_state_t n;
  logic access;
  logic [5:0] dec;
  logic [6:0] hit_v;
  logic [6:0] edge_v;
  logic [6:0] rise_v;
  logic [6:0] fall_v;
  logic [6:0] wr_ctrl_v;
  logic [9:0] duty0;

  // Splits an index into valid bit, channel slot and sub-register
  function automatic logic [5:0] ccpm_decode(input logic [11:0] idx);
    logic [11:0] off;
    logic [2:0] slot;
    logic [1:0] sub;
    off = idx - `CCPM_IDX_CH10_CTRL;
    slot = 3'((off / 12'h003) & 12'h007);
    sub = 2'((off % 12'h003) & 12'h003);
    if (idx < `CCPM_IDX_CH10_CTRL || idx > `CCPM_IDX_LAST)
    begin
      return 6'h00;
    end
    return {1'b1, slot, sub};
  endfunction

  // Ten-bit duty from low byte and control bits
  function automatic logic [9:0] ccpm_duty(input logic [15:0] v,
                                           input ccpm_ctrl_t c);
    return {v[7:0], c.duty_low_bits};
  endfunction

  assign access = apb_req.psel & apb_req.penable & ~s.pready;
  assign dec = ccpm_decode(apb_req.paddr[13:2]);
  assign rise_v = s.sync2 & ~s.pin_prev;
  assign fall_v = ~s.sync2 & s.pin_prev;
  assign duty0 = ccpm_duty(s.value[0], s.ctrl[0]);

  for (genvar g = 0; g < `CCPM_CHANNELS; g++)
  begin : g_ch
    assign hit_v[g] = (timer_value == s.value[g]);
    assign edge_v[g] = hit_v[g] & ~s.match_prev[g];
    assign wr_ctrl_v[g] = access & apb_req.pwrite & dec[5]
                          & (dec[4:2] == 3'(g))
                          & (apb_req.paddr[1:0] == 2'h0)
                          & (apb_req.paddr[15:14] == 2'h0)
                          & (dec[1:0] == `CCPM_SUB_CTRL);
  end

  always_comb
  begin
    logic aligned;
    logic [11:0] idx;
    logic [3:0] m;
    logic [3:0] nm;
    logic [2:0] sl;
    aligned = 1'b0;
    idx = 12'h000;
    m = 4'h0;
    nm = 4'h0;
    sl = 3'h0;
    n = s;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.timer_reset = 1'b0;
    n.sync1 = pin_in;
    n.sync2 = s.sync1;
    n.pin_prev = s.sync2;
    n.match_prev = hit_v;
    aligned = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[15:14] == 2'h0);
    idx = apb_req.paddr[13:2];
    sl = dec[4:2];
    if (access)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      if (!aligned)
      begin
        n.pslverr = 1'b1;
      end
      else if (dec[5] && dec[1:0] == `CCPM_SUB_CTRL)
      begin
        n.prdata = {26'h0, s.ctrl[sl]};
        if (apb_req.pwrite)
        begin
          n.ctrl[sl] = apb_req.pwdata[5:0];
          nm = apb_req.pwdata[3:0];
          n.prescale[sl] = 4'h0;
          n.pin[sl] = (nm == CCPM_CMP_CLEAR);
          n.oe[sl] = (nm == CCPM_CMP_TOGGLE) || (nm == CCPM_CMP_SET)
                     || (nm == CCPM_CMP_CLEAR) || (nm == CCPM_CMP_SPECIAL)
                     || (nm[3:2] == 2'b11);
        end
      end
      else if (dec[5] && dec[1:0] == `CCPM_SUB_LOW)
      begin
        n.prdata = {24'h0, s.value[sl][7:0]};
        if (apb_req.pwrite)
        begin
          n.value[sl][7:0] = apb_req.pwdata[7:0];
        end
      end
      else if (dec[5])
      begin
        n.prdata = {24'h0, s.value[sl][15:8]};
        if (apb_req.pwrite)
        begin
          n.value[sl][15:8] = apb_req.pwdata[7:0];
        end
      end
      else if (idx == `CCPM_IDX_STATUS)
      begin
        n.prdata = {25'h0, s.flag};
        if (apb_req.pwrite)
        begin
          n.flag = s.flag & ~apb_req.pwdata[6:0];
        end
      end
      else if (idx == `CCPM_IDX_MASK)
      begin
        n.prdata = {25'h0, s.mask};
        if (apb_req.pwrite)
        begin
          n.mask = apb_req.pwdata[6:0];
        end
      end
      else
      begin
        n.pslverr = 1'b1;
      end
    end
    // Channel events come after bus clears so a set wins
    for (int k = 0; k < `CCPM_CHANNELS; k++)
    begin
      m = s.ctrl[k].channel_mode_select;
      if (!wr_ctrl_v[k])
      begin
        if (m[3:2] == 2'b11)
        begin
          n.oe[k] = 1'b1;
          n.pin[k] = ({pwm_count} < ccpm_duty(s.value[k], s.ctrl[k]));
        end
        else
        begin
          case (m)
            CCPM_OFF:
            begin
              n.pin[k] = 1'b0;
              n.oe[k] = 1'b0;
              n.prescale[k] = 4'h0;
            end
            CCPM_CMP_TOGGLE:
            begin
              if (edge_v[k])
              begin
                n.pin[k] = ~s.pin[k];
                n.flag[k] = 1'b1;
              end
            end
            CCPM_CAP_FALL:
            begin
              if (fall_v[k])
              begin
                n.value[k] = timer_value;
                n.flag[k] = 1'b1;
              end
            end
            CCPM_CAP_RISE:
            begin
              if (rise_v[k])
              begin
                n.value[k] = timer_value;
                n.flag[k] = 1'b1;
              end
            end
            CCPM_CAP_FOUR, CCPM_CAP_SIXTEEN:
            begin
              if (rise_v[k])
              begin
                n.prescale[k] = s.prescale[k] + 4'h1;
                if (s.prescale[k] == ((m == CCPM_CAP_FOUR) ?
                    `CCPM_PRE_FOUR : `CCPM_PRE_SIXTEEN))
                begin
                  n.prescale[k] = 4'h0;
                  n.value[k] = timer_value;
                  n.flag[k] = 1'b1;
                end
              end
            end
            CCPM_CMP_SET, CCPM_CMP_CLEAR:
            begin
              if (edge_v[k])
              begin
                n.pin[k] = (m == CCPM_CMP_SET);
                n.flag[k] = 1'b1;
              end
            end
            CCPM_CMP_IRQ:
            begin
              n.oe[k] = 1'b0;
              if (edge_v[k])
              begin
                n.flag[k] = 1'b1;
              end
            end
            CCPM_CMP_SPECIAL:
            begin
              if (edge_v[k])
              begin
                n.timer_reset = 1'b1;
                n.flag[k] = 1'b1;
              end
            end
            default:
            begin
              n.oe[k] = 1'b0;
            end
          endcase
        end
      end
    end
    n.irq = |(n.flag & n.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign pin_out = s.pin;
  assign pin_oe = s.oe;
  assign timer_reset = s.timer_reset;
  assign irq = s.irq;

  // Checks on slot 0 and the bus
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence ccpm_match0;
    edge_v[0] && !wr_ctrl_v[0];
  endsequence

  sequence ccpm_rise0;
    rise_v[0] && !wr_ctrl_v[0];
  endsequence

  sequence ccpm_fall0;
    fall_v[0] && !wr_ctrl_v[0];
  endsequence

  a_off_released: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_OFF && !wr_ctrl_v[0])
    |=> !pin_oe[0] && !pin_out[0])
    else $error("disabled channel still drives");

  a_toggle_on_match: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CMP_TOGGLE) and ccpm_match0
    |=> (pin_out[0] != $past(pin_out[0])) && s.flag[0])
    else $error("toggle mode missed a match");

  a_capture_rise: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CAP_RISE && rise_v[0]
     && !wr_ctrl_v[0])
    |=> s.value[0] == $past(timer_value) && s.flag[0])
    else $error("rising capture lost");

  a_capture_fourth: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CAP_FOUR && rise_v[0]
     && !wr_ctrl_v[0] && s.prescale[0] == 4'h3)
    |=> s.value[0] == $past(timer_value) && s.prescale[0] == 4'h0)
    else $error("fourth edge capture lost");

  a_force_high: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CMP_SET) and ccpm_match0
    |=> pin_out[0] && s.flag[0])
    else $error("pin not forced high");

  a_force_low: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CMP_CLEAR) and ccpm_match0
    |=> !pin_out[0] && s.flag[0])
    else $error("pin not forced low");

  a_irq_only: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CMP_IRQ && !wr_ctrl_v[0])
    |=> !pin_oe[0])
    else $error("interrupt-only mode drives pin");

  a_special_trigger: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CMP_SPECIAL) and ccpm_match0
    |=> timer_reset && s.flag[0])
    else $error("special trigger missing");

  a_pwm_duty: assert property (
    (s.ctrl[0].channel_mode_select[3:2] == 2'b11 && !wr_ctrl_v[0])
    |=> pin_oe[0] && pin_out[0] == ($past(pwm_count) < $past(duty0)))
    else $error("pwm level wrong");

  a_apb_answer: assert property (
    access |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  a_irq_level: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CMP_IRQ && s.mask[0])
    and ccpm_match0
    |=> s.flag[0] && irq)
    else $error("match did not raise interrupt");

  a_capture_fall: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CAP_FALL) and ccpm_fall0
    |=> s.value[0] == $past(timer_value) && s.flag[0])
    else $error("falling capture lost");

  a_capture_sixteenth: assert property (
    (s.ctrl[0].channel_mode_select == CCPM_CAP_SIXTEEN
     && s.prescale[0] == 4'hF) and ccpm_rise0
    |=> s.value[0] == $past(timer_value) && s.prescale[0] == 4'h0)
    else $error("sixteenth edge capture lost");

  a_mode_init_low: assert property (
    wr_ctrl_v[0] && apb_req.pwdata[3:0] == CCPM_CMP_SET
    |=> pin_oe[0] && !pin_out[0])
    else $error("set mode did not start low");

  a_mode_init_high: assert property (
    wr_ctrl_v[0] && apb_req.pwdata[3:0] == CCPM_CMP_CLEAR
    |=> pin_oe[0] && pin_out[0])
    else $error("clear mode did not start high");

  a_low_byte_write: assert property (
    (access && apb_req.pwrite && apb_req.paddr[1:0] == 2'h0
     && apb_req.paddr[15:14] == 2'h0 && dec == {1'b1, 3'h0, `CCPM_SUB_LOW}
     && s.ctrl[0].channel_mode_select[3:2] != 2'b01)
    |=> s.value[0][7:0] == $past(apb_req.pwdata[7:0]))
    else $error("low byte write lost");
endmodule

/* File: ccpm_far.sv */
// Far-side model: shared timers and channel pins
`timescale 1ns/1ps
module ccpm_far(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic timer_reset,
  input wire logic [6:0] pin_drv,
  output logic [15:0] timer_value,
  output logic [9:0] pwm_count,
  output logic [6:0] pin_in
);
  assign pin_in = pin_drv;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_value <= 16'h0000;
      pwm_count <= 10'h000;
    end
    else
    begin
      if (timer_reset)
        timer_value <= 16'h0000;
      else if (run)
        timer_value <= timer_value + 16'h0001;
      if (run)
        pwm_count <= pwm_count + 10'h001;
    end
  end
endmodule

/* File: ccpm_tb_top.sv */
// Self-checking bench of the capture/compare/PWM block
`timescale 1ns/1ps
module ccpm_tb_top;
  import ccpm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic run = 1'b0;
  logic [6:0] pin_drv = 7'h00;
  ccpm_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_reset, irq, err, trs;
  logic [15:0] timer_value;
  logic [9:0] pwm_count;
  logic [6:0] pin_in, pin_out, pin_oe;
  logic [31:0] rd;
  int err_count = 0;
  int checks = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk)
    if (timer_reset === 1'b1)
      trs <= 1'b1;
  ccpm_top i_dut(.pclk(pclk), .presetn(presetn), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_value(timer_value), .pwm_count(pwm_count), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .timer_reset(timer_reset),
    .irq(irq));
  ccpm_far i_far(.pclk(pclk), .presetn(presetn), .run(run),
    .timer_reset(timer_reset), .pin_drv(pin_drv),
    .timer_value(timer_value), .pwm_count(pwm_count), .pin_in(pin_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      err_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge pclk);
  endtask
  // Index i is relative to the first control register
  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, 16'((32'hF00 + i) * 4), d);
  endtask
  task automatic rc(input int i, input logic [31:0] e);
    apb(1'b0, 16'((32'hF00 + i) * 4), 32'h0);
    chk(rd, e);
  endtask
  task automatic t_regs();
    for (int k = 0; k < 7; k++)
    begin
      rc(3 * k, 32'h0);
      wr(3 * k, 32'hFF);
      rc(3 * k, 32'h3F);
      wr(3 * k + 1, 32'hA0 + k);
      rc(3 * k + 1, 32'hA0 + k);
      rc(3 * k + 2, 32'h0);
      wr(3 * k, 32'h0);
    end
    apb(1'b0, 16'h3C54, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_cmp();
    logic [3:0] m[5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
    logic [15:0] v;
    logic p;
    int n;
    wr(33, 32'h1);
    foreach (m[j])
    begin
      v = timer_value + 16'h0014;
      wr(1, v[7:0]);
      wr(2, v[15:8]);
      wr(0, m[j]);
      p = pin_out[0];
      chk(pin_oe[0], m[j] != 4'hA);
      if (m[j] == 4'h8 || m[j] == 4'h9)
        chk(p, m[j] == 4'h9);
      trs = 1'b0;
      run <= 1'b1;
      n = 0;
      while (irq !== 1'b1 && n < 100)
      begin
        tick(1);
        n++;
      end
      chk(irq, 1'b1);
      if (irq !== 1'b1)
        results();
      tick(1);
      run <= 1'b0;
      if (m[j] < 4'hA)
        chk(pin_out[0], m[j] == 4'h2 ? !p : m[j] == 4'h8);
      chk(trs, m[j] == 4'hB);
      wr(32, 32'h1);
      tick(1);
      chk(irq, 1'b0);
    end
    wr(0, 32'h0);
    $display("test compare done");
  endtask
  task automatic t_cap();
    logic [3:0] m[4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int p[4] = '{1, 1, 4, 16};
    foreach (m[j])
    begin
      pin_drv[0] <= (j == 0);
      run <= 1'b1;
      tick(3);
      run <= 1'b0;
      tick(3);
      wr(0, m[j]);
      wr(32, 32'h1);
      for (int e = 0; e < p[j]; e++)
      begin
        rc(32, 32'h0);
        pin_drv[0] <= ~pin_drv[0];
        tick(6);
        if (e == p[j] - 1)
          rc(32, 32'h1);
        pin_drv[0] <= ~pin_drv[0];
        tick(6);
      end
      rc(1, timer_value[7:0]);
      rc(2, timer_value[15:8]);
    end
    wr(0, 32'h0);
    $display("test capture done");
  endtask
  task automatic t_pwm();
    logic [9:0] c;
    wr(7, 32'h1);
    for (int m = 12; m < 16; m++)
    begin
      wr(6, 32'h20 | m);
      run <= 1'b1;
      tick(1);
      chk(pin_oe[2], 1'b1);
      repeat (1030)
      begin
        c = pwm_count;
        tick(1);
        chk(pin_out[2], c < 10'h006);
      end
    end
    run <= 1'b0;
    $display("test pwm done");
  endtask
  initial
  begin
    tick(4);
    presetn <= 1'b1;
    tick(1);
    t_regs();
    t_cmp();
    t_cap();
    t_pwm();
    results();
  end
endmodule
